// ===== vdfs_channel.sv
// supervision of one current-regulated valve driver channel
//
// Contract
// - target minus measured above threshold for whole delay sets regulation_error_flag
// - threshold is 25 LSB of 2.197 mA, checked only in regulation mode
// - during regulation error the loop keeps running at full or minimum duty
// - regulation error never switches the driver off, only forces full or minimum duty
// - regulation_error_flag latches, cleared by a controller read
// - regulation_disable high turns the channel into a plain PWM switch
// - PWM duty is the 8 upper bits of the target word
// - first PWM period follows first_duty_control
// - 10-bit target, zero means off, all ones means 2.25 A
// - low output for filter time while off sets open-load flag only
// - drain_state is drain above reference filtered over filter_period
// - overcurrent for filter time switches off and sets fault bit
// - after overcurrent, fault_clear then a target command resumes driving
// - overtemperature for filter time switches off, sets bit, clears turn-on command
// - overtemperature recovery needs normal temperature, fault_clear, then target command
`timescale 1ns/100ps
`include "vdfs_map.svh"
module vdfs_channel
    import vdfs_pkg::*;
#(
    parameter int FILTER_CYC = `VDFS_FILTER_CYC,
    parameter int CRERR_CYC  = `VDFS_CRERR_CYC
)
(
    input  wire logic         CORE_CLK,
    input  wire logic         ARST_N,
    input  wire vdfs_target_t TARGET,
    input  wire logic         TARGET_WRITE,
    input  wire logic         REGULATION_DISABLE,
    input  wire logic         FIRST_DUTY_CONTROL,
    input  wire logic         MIN_DUTY_SELECT,
    input  wire logic         FAULT_CLEAR,
    input  wire logic         FLAG_READ,
    input  wire vdfs_target_t ADC_CURRENT,
    input  wire logic         DRIVER_ON,
    input  wire vdfs_cond_s   COND_PIN,
    output vdfs_flags_s       FLAGS,
    output logic              DRIVE_ENABLE,
    output logic              PWM_MODE,
    output logic [7:0]        PWM_DUTY,
    output logic              FIRST_DUTY,
    output logic              FORCE_FULL_DUTY,
    output logic              FORCE_MIN_DUTY,
    output vdfs_target_t      REGULATION_TARGET
);
    localparam vdfs_cnt_t FILT_LIM  = vdfs_cnt_t'(FILTER_CYC);
    localparam vdfs_cnt_t CRERR_LIM = vdfs_cnt_t'(CRERR_CYC);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    vdfs_cond_s sync1;
    vdfs_cond_s cond;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1 <= '0;
            cond  <= '0;
        end else begin
            sync1 <= COND_PIN;
            cond  <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // condition filters
    // ----------------------------------------------------------------
    function automatic logic over_thresh(input vdfs_target_t tgt, input vdfs_target_t meas);
        logic [10:0] diff;
        diff = {1'b0, tgt} - {1'b0, meas};
        return !diff[10] && (diff[9:0] > `VDFS_ERR_THRESH);
    endfunction

    logic q_ol;
    logic q_ds;
    logic q_oc;
    logic q_ot;
    logic q_cr;
    logic cr_cond;

    vdfs_target_t cmd;

    // check only in regulation mode with a nonzero stored command
    assign cr_cond = !REGULATION_DISABLE && (cmd != '0) && DRIVE_ENABLE
                     && over_thresh(cmd, ADC_CURRENT);

    vdfs_filter u_ol (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .cond(cond.below_open_load && !DRIVER_ON),
                      .limit(FILT_LIM), .qualified(q_ol));
    vdfs_filter u_ds (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .cond(cond.above_reference),
                      .limit(FILT_LIM), .qualified(q_ds));
    vdfs_filter u_oc (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .cond(cond.over_current),
                      .limit(FILT_LIM), .qualified(q_oc));
    vdfs_filter u_ot (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .cond(cond.over_temp),
                      .limit(FILT_LIM), .qualified(q_ot));
    vdfs_filter u_cr (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .cond(cr_cond),
                      .limit(CRERR_LIM), .qualified(q_cr));

    // ----------------------------------------------------------------
    // fault state and flags
    // ----------------------------------------------------------------
    vdfs_state_e  state;
    vdfs_state_e  next_state;
    vdfs_flags_s  next_flags;
    vdfs_target_t next_cmd;
    logic         first;
    logic         next_first;

    always_comb begin
        next_state = state;
        next_flags = FLAGS;
        next_cmd   = cmd;
        next_first = first;
        next_flags.drain_state = q_ds;
        // controller read clears, a new event in the same cycle wins
        if (FLAG_READ) begin
            next_flags.regulation_error_flag = 1'b0;
            next_flags.open_load             = 1'b0;
        end
        if (q_cr) begin
            next_flags.regulation_error_flag = 1'b1;
        end
        if (q_ol) begin
            next_flags.open_load = 1'b1;
        end
        if (TARGET_WRITE) begin
            next_cmd   = TARGET;
            next_first = 1'b1;
        end else if (PWM_MODE) begin
            next_first = 1'b0;
        end
        unique case (state)
            VDFS_RUN: begin
                if (q_ot) begin
                    next_state = VDFS_OT_OFF;
                    next_flags.overtemp = 1'b1;
                    next_cmd = '0;
                end else if (q_oc) begin
                    next_state = VDFS_OC_OFF;
                    next_flags.overcurrent = 1'b1;
                end
            end
            VDFS_OC_OFF: begin
                if (FAULT_CLEAR) begin
                    next_state = VDFS_ARMED;
                    next_flags.overcurrent = 1'b0;
                end
            end
            VDFS_OT_OFF: begin
                if (FAULT_CLEAR && !cond.over_temp) begin
                    next_state = VDFS_ARMED;
                    next_flags.overtemp = 1'b0;
                end
            end
            VDFS_ARMED: begin
                if (q_ot) begin
                    next_state = VDFS_OT_OFF;
                    next_flags.overtemp = 1'b1;
                    next_cmd = '0;
                end else if (TARGET_WRITE) begin
                    next_state = VDFS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= VDFS_RUN;
            FLAGS <= '0;
            cmd   <= '0;
            first <= 1'b0;
        end else begin
            state <= next_state;
            FLAGS <= next_flags;
            cmd   <= next_cmd;
            first <= next_first;
        end
    end

    // ----------------------------------------------------------------
    // driver steering outputs
    // ----------------------------------------------------------------
    logic         next_en;
    logic         next_pwm;
    logic [7:0]   next_duty;
    logic         next_fd;
    logic         next_full;
    logic         next_min;
    vdfs_target_t next_tgt;

    always_comb begin
        // a regulation error never enters this enable
        next_en   = (state == VDFS_RUN) && (cmd != '0);
        next_pwm  = REGULATION_DISABLE;
        next_duty = cmd[9:2];
        next_fd   = first && FIRST_DUTY_CONTROL;
        next_full = q_cr && !MIN_DUTY_SELECT && !REGULATION_DISABLE;
        next_min  = q_cr && MIN_DUTY_SELECT && !REGULATION_DISABLE;
        next_tgt  = cmd;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DRIVE_ENABLE      <= 1'b0;
            PWM_MODE          <= 1'b0;
            PWM_DUTY          <= 8'h00;
            FIRST_DUTY        <= 1'b0;
            FORCE_FULL_DUTY   <= 1'b0;
            FORCE_MIN_DUTY    <= 1'b0;
            REGULATION_TARGET <= '0;
        end else begin
            DRIVE_ENABLE      <= next_en;
            PWM_MODE          <= next_pwm;
            PWM_DUTY          <= next_duty;
            FIRST_DUTY        <= next_fd;
            FORCE_FULL_DUTY   <= next_full;
            FORCE_MIN_DUTY    <= next_min;
            REGULATION_TARGET <= next_tgt;
        end
    end
endmodule

// ===== vdfs_map.svh
// channel count, widths, threshold and timing counts of the valve driver fault supervisor
`ifndef VDFS_MAP_SVH
`define VDFS_MAP_SVH
`define VDFS_CHANNELS        4
`define VDFS_TARGET_W        10
`define VDFS_DUTY_W          8
`define VDFS_ERR_THRESH      10'h019
`define VDFS_CLK_MHZ         200
`define VDFS_FILTER_US       20
`define VDFS_FILTER_CYC      (`VDFS_FILTER_US * `VDFS_CLK_MHZ)
`define VDFS_CRERR_US        100
`define VDFS_CRERR_CYC       (`VDFS_CRERR_US * `VDFS_CLK_MHZ)
`define VDFS_CNT_W           16
`endif

// ===== vdfs_pkg.sv
// types of the valve driver fault supervisor
`include "vdfs_map.svh"
package vdfs_pkg;
    typedef logic [`VDFS_TARGET_W-1:0] vdfs_target_t;
    typedef logic [`VDFS_CNT_W-1:0]    vdfs_cnt_t;
    typedef enum logic [1:0] {
        VDFS_RUN     = 2'b00,
        VDFS_OC_OFF  = 2'b01,
        VDFS_OT_OFF  = 2'b10,
        VDFS_ARMED   = 2'b11
    } vdfs_state_e;
    typedef struct packed {
        logic open_load;
        logic drain_state;
        logic overcurrent;
        logic overtemp;
        logic regulation_error_flag;
    } vdfs_flags_s;
    typedef struct packed {
        logic below_open_load;
        logic above_reference;
        logic over_current;
        logic over_temp;
    } vdfs_cond_s;
endpackage

// ===== vdfs_filter.sv
// qualifies one condition that must hold continuously for a number of cycles
`timescale 1ns/100ps
module vdfs_filter
    import vdfs_pkg::*;
(
    input  wire logic      CORE_CLK,
    input  wire logic      ARST_N,
    input  wire logic      cond,
    input  wire vdfs_cnt_t limit,
    output logic           qualified
);
    vdfs_cnt_t cnt;
    vdfs_cnt_t next_cnt;
    logic      next_qualified;

    always_comb begin
        next_cnt       = cnt;
        next_qualified = 1'b0;
        if (!cond) begin
            next_cnt = '0;
        end else if (cnt >= limit - 16'h0001) begin
            next_qualified = 1'b1;
        end else begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt       <= '0;
            qualified <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            qualified <= next_qualified;
        end
    end
endmodule

// ===== vdfs_channel_assertions.sv
// port checks of one valve driver channel
`timescale 1ns/100ps
module vdfs_channel_assertions
    import vdfs_pkg::*;
(
    input wire logic         CORE_CLK,
    input wire logic         ARST_N,
    input wire vdfs_target_t TARGET,
    input wire logic         TARGET_WRITE,
    input wire logic         FAULT_CLEAR,
    input wire logic         FLAG_READ,
    input wire vdfs_cond_s   COND_PIN,
    input wire vdfs_flags_s  FLAGS,
    input wire logic         DRIVE_ENABLE,
    input wire logic         PWM_MODE,
    input wire logic [7:0]   PWM_DUTY,
    input wire logic         FORCE_FULL_DUTY,
    input wire logic         FORCE_MIN_DUTY,
    input wire vdfs_target_t REGULATION_TARGET
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    a_duty_upper_bits: assert property (PWM_DUTY == REGULATION_TARGET[9:2])
        else $error("duty not upper target bits");
    a_zero_target_off: assert property (TARGET_WRITE && TARGET == '0 |-> ##2 !DRIVE_ENABLE)
        else $error("zero target left driver on");
    a_oc_held_off: assert property (FLAGS.overcurrent && $past(FLAGS.overcurrent) |-> !DRIVE_ENABLE)
        else $error("driver on during overcurrent");
    a_oc_clear_armed: assert property ($fell(FLAGS.overcurrent) |-> !DRIVE_ENABLE)
        else $error("driver on before target command");
    a_ot_shutdown: assert property ($rose(FLAGS.overtemp) |-> ##2 (!DRIVE_ENABLE && REGULATION_TARGET == '0))
        else $error("overtemp did not stop driver");
    a_ot_clear_ignored: assert property (FAULT_CLEAR && FLAGS.overtemp && $past(COND_PIN.over_temp, 2)
        && $past(COND_PIN.over_temp, 3) |=> FLAGS.overtemp)
        else $error("clear accepted while hot");
    a_regerr_latched: assert property (FLAGS.regulation_error_flag && !FLAG_READ |=> FLAGS.regulation_error_flag)
        else $error("error flag dropped unread");
    a_drain_restart: assert property (!COND_PIN.above_reference [*4] ##1 COND_PIN.above_reference [*6]
        |=> !FLAGS.drain_state)
        else $error("drain state set too early");
    a_pwm_no_force: assert property (PWM_MODE && $past(PWM_MODE) |-> !FORCE_FULL_DUTY && !FORCE_MIN_DUTY)
        else $error("duty forced in switch mode");
    c_oc: cover property ($rose(FLAGS.overcurrent));
    c_ot: cover property ($rose(FLAGS.overtemp));
    c_regerr: cover property ($rose(FLAGS.regulation_error_flag));
endmodule
bind vdfs_channel vdfs_channel_assertions chk (.*);

// ===== vdfs_mcu.sv
// controller model issuing target, clear and read commands
`timescale 1ns/100ps
module vdfs_mcu
    import vdfs_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire vdfs_flags_s FLAGS,
    output vdfs_target_t     TARGET,
    output logic             TARGET_WRITE,
    output logic             FAULT_CLEAR,
    output logic             FLAG_READ
);
    initial begin
        TARGET = '0;
        TARGET_WRITE = 1'b0;
        FAULT_CLEAR = 1'b0;
        FLAG_READ = 1'b0;
    end
    task send(input vdfs_target_t v);
        TARGET = v;
        TARGET_WRITE = 1'b1;
        @(posedge CORE_CLK) #1;
        TARGET_WRITE = 1'b0;
        TARGET = ~v; // stale word, no longer valid
    endtask
    task clear;
        FAULT_CLEAR = 1'b1;
        @(posedge CORE_CLK) #1;
        FAULT_CLEAR = 1'b0;
    endtask
    task read;
        FLAG_READ = 1'b1;
        @(posedge CORE_CLK) #1;
        FLAG_READ = 1'b0;
    endtask
    task recover(input vdfs_target_t v);
        clear();
        send(v);
    endtask
    task stop_faulty;
        if (FLAGS.regulation_error_flag === 1'b1) begin
            read();
            send('0);
        end
    endtask
endmodule

// ===== vdfs_channel_bench.sv
// self-checking bench of one valve driver channel
`timescale 1ns/100ps
module vdfs_channel_bench;
    import vdfs_pkg::*;
    logic CORE_CLK, ARST_N, DRIVER_ON;
    logic REGULATION_DISABLE, FIRST_DUTY_CONTROL, MIN_DUTY_SELECT;
    vdfs_target_t ADC_CURRENT, TARGET, REGULATION_TARGET;
    vdfs_cond_s COND_PIN;
    vdfs_flags_s FLAGS;
    logic TARGET_WRITE, FAULT_CLEAR, FLAG_READ, DRIVE_ENABLE, PWM_MODE, FIRST_DUTY, FORCE_FULL_DUTY, FORCE_MIN_DUTY;
    logic [7:0] PWM_DUTY;
    int miscompares = 0, compares = 0;
    vdfs_channel #(.FILTER_CYC(8), .CRERR_CYC(16)) dut (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .TARGET(TARGET), .TARGET_WRITE(TARGET_WRITE),
        .REGULATION_DISABLE(REGULATION_DISABLE), .FIRST_DUTY_CONTROL(FIRST_DUTY_CONTROL),
        .MIN_DUTY_SELECT(MIN_DUTY_SELECT), .FAULT_CLEAR(FAULT_CLEAR), .FLAG_READ(FLAG_READ),
        .ADC_CURRENT(ADC_CURRENT), .DRIVER_ON(DRIVER_ON), .COND_PIN(COND_PIN), .FLAGS(FLAGS),
        .DRIVE_ENABLE(DRIVE_ENABLE), .PWM_MODE(PWM_MODE), .PWM_DUTY(PWM_DUTY), .FIRST_DUTY(FIRST_DUTY),
        .FORCE_FULL_DUTY(FORCE_FULL_DUTY), .FORCE_MIN_DUTY(FORCE_MIN_DUTY),
        .REGULATION_TARGET(REGULATION_TARGET)
    );
    vdfs_mcu mcu (
        .CORE_CLK(CORE_CLK), .FLAGS(FLAGS), .TARGET(TARGET), .TARGET_WRITE(TARGET_WRITE),
        .FAULT_CLEAR(FAULT_CLEAR), .FLAG_READ(FLAG_READ)
    );
    task cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    task chk(input string what, input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task t_target;
        vdfs_target_t v[4] = '{10'h3ff, 10'h001, 10'h2a4, 10'h000};
        REGULATION_DISABLE = 1'b1;
        FIRST_DUTY_CONTROL = 1'b1;
        foreach (v[i]) begin
            mcu.send(v[i]);
            cyc(1);
            chk("first duty", {9'h0, FIRST_DUTY}, 10'h001);
            cyc(1);
            chk("first done", {9'h0, FIRST_DUTY}, 10'h000);
            chk("target", REGULATION_TARGET, v[i]);
            chk("duty", {2'b0, PWM_DUTY}, {2'b0, v[i][9:2]});
            chk("enable", {9'h0, DRIVE_ENABLE}, {9'h0, v[i] != '0});
            chk("pwm mode", {9'h0, PWM_MODE}, 10'h001);
        end
        REGULATION_DISABLE = 1'b0;
        FIRST_DUTY_CONTROL = 1'b0;
    endtask
    task t_regerr;
        mcu.send(10'h100);
        DRIVER_ON = 1'b1;
        ADC_CURRENT = 10'h0e7;
        cyc(40);
        chk("error at 25", {9'h0, FLAGS.regulation_error_flag}, 10'h000);
        ADC_CURRENT = 10'h0e6;
        cyc(40);
        chk("error at 26", {9'h0, FLAGS.regulation_error_flag}, 10'h001);
        chk("full duty", {9'h0, FORCE_FULL_DUTY}, 10'h001);
        chk("still on", {9'h0, DRIVE_ENABLE}, 10'h001);
        MIN_DUTY_SELECT = 1'b1;
        cyc(2);
        chk("min duty", {9'h0, FORCE_MIN_DUTY}, 10'h001);
        chk("no full duty", {9'h0, FORCE_FULL_DUTY}, 10'h000);
        MIN_DUTY_SELECT = 1'b0;
        ADC_CURRENT = 10'h100;
        cyc(3);
        chk("latched", {9'h0, FLAGS.regulation_error_flag}, 10'h001);
        mcu.stop_faulty();
        cyc(2);
        chk("read clears", {9'h0, FLAGS.regulation_error_flag}, 10'h000);
        chk("stopped", {9'h0, DRIVE_ENABLE}, 10'h000);
        DRIVER_ON = 1'b0;
    endtask
    task t_openload;
        COND_PIN.below_open_load = 1'b1;
        cyc(20);
        chk("open load", {9'h0, FLAGS.open_load}, 10'h001);
        COND_PIN.below_open_load = 1'b0;
        COND_PIN.above_reference = 1'b1;
        cyc(6);
        COND_PIN.above_reference = 1'b0;
        cyc(10);
        chk("drain short", {9'h0, FLAGS.drain_state}, 10'h000);
        COND_PIN.above_reference = 1'b1;
        cyc(20);
        chk("drain", {9'h0, FLAGS.drain_state}, 10'h001);
        COND_PIN.above_reference = 1'b0;
    endtask
    task t_overcurrent;
        mcu.send(10'h200);
        COND_PIN.over_current = 1'b1;
        cyc(20);
        chk("oc flag", {9'h0, FLAGS.overcurrent}, 10'h001);
        chk("oc off", {9'h0, DRIVE_ENABLE}, 10'h000);
        COND_PIN.over_current = 1'b0;
        mcu.clear();
        cyc(3);
        chk("armed off", {9'h0, DRIVE_ENABLE}, 10'h000);
        chk("oc cleared", {9'h0, FLAGS.overcurrent}, 10'h000);
        mcu.send(10'h200);
        cyc(2);
        chk("resumed", {9'h0, DRIVE_ENABLE}, 10'h001);
    endtask
    task t_overtemp;
        COND_PIN.over_temp = 1'b1;
        cyc(20);
        chk("ot off", {9'h0, DRIVE_ENABLE}, 10'h000);
        chk("ot cmd", REGULATION_TARGET, 10'h000);
        mcu.clear();
        cyc(2);
        chk("hot clear", {9'h0, FLAGS.overtemp}, 10'h001);
        COND_PIN.over_temp = 1'b0;
        cyc(4);
        mcu.recover(10'h155);
        cyc(2);
        chk("ot resumed", {9'h0, DRIVE_ENABLE}, 10'h001);
    endtask
    initial begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    initial begin
        #10us;
        miscompares++;
        stop_test();
    end
    initial begin
        ARST_N = 1'b0;
        DRIVER_ON = 1'b0;
        REGULATION_DISABLE = 1'b0;
        FIRST_DUTY_CONTROL = 1'b0;
        MIN_DUTY_SELECT = 1'b0;
        ADC_CURRENT = '0;
        COND_PIN = '0;
        repeat (20) @(posedge CORE_CLK);
        #1 ARST_N = 1'b1;
        cyc(1);
        t_target();
        t_regerr();
        t_openload();
        t_overcurrent();
        t_overtemp();
        stop_test();
    end
endmodule
